// ### include/amso_pkg.sv
// Purpose: shared constants and carriers for the address map and start-up option block
// Assumes: one 50 MHz clock, asynchronous active-low reset
// Notes: option bit meanings beyond the erased default are not decoded here
package amso_pkg;
	localparam int PC_W = 12;
	localparam int RA_W = 8;
	localparam int DW = 8;
	localparam logic [11:0] PROG_TOP = 12'hfff;
	localparam logic [11:0] VEC_TOP = 12'h0ff;
	localparam logic [11:0] OPT_LO = 12'h03c;
	localparam logic [11:0] OPT_HI = 12'h03f;
	localparam logic [11:0] OPT_A = 12'h03e;
	localparam logic [11:0] OPT_B = 12'h03f;
	localparam logic [11:0] RESET_PC = 12'h100;
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [7:0] GP_TOP = 8'hbf;
	localparam logic [7:0] WORK_LO = 8'hc0;
	localparam logic [7:0] WORK_HI = 8'hcf;
	localparam int LVR_BIT = 7;
	localparam int OSC_BIT = 1;
	localparam int CTRL_BYTES = 37;
	localparam int GP_BYTES = 208;
	// programming pin sampling
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		AMSO_ST_OPT_A = 2'b00,
		AMSO_ST_OPT_B = 2'b01,
		AMSO_ST_RUN = 2'b10
	} amso_state_t;

	typedef struct packed {
		logic low_voltage_reset;
		logic internal_rc;
		logic [7:0] opt_a;
		logic [7:0] opt_b;
	} amso_cfg_t;

	typedef struct packed {
		logic sda_out;
		logic sda_oe;
	} amso_sda_t;
endpackage

// ### rtl/amso_regfile.sv
// Purpose: 8-bit internal register file, single page
// Assumes: control space above cfh lives in peripherals outside
// Notes: flip-flop storage, one write port and one read port
`timescale 1ns/1ps
module amso_regfile #(
	parameter int DEPTH = 208
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];
	logic [7:0] rd_q;

	// refuse a depth the address decode cannot serve
	if (DEPTH != amso_pkg::GP_BYTES) begin : g_bad_depth
		$error("regfile depth must match gp space");
	end

	// only 00h..cfh stored; one page, no page select
	wire in_range = (addr <= amso_pkg::WORK_HI);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_q <= 8'h00;
		end else begin
			if (wr_en && in_range) begin
				mem[addr] <= wdata;
			end
			rd_q <= in_range ? mem[addr] : 8'h00;
		end
	end
	assign rdata = rd_q;
endmodule

// ### rtl/amso_core.sv
// Purpose: program memory map, reset start-up option load, register bus steering, programming pins
// Assumes: flash array read combinationally through prog_rdata, registered here
// Notes: option bytes are loaded before the first fetch and kept until reset
`timescale 1ns/1ps
// Overview of operation
// - program memory addressed over a twelve-bit bus
// - four kilobytes of flash, addresses 000h to fffh
// - lowest 256 bytes reserved for interrupt vectors
// - unused vectors act as program memory; 3ch-3fh hold option cells
// - first fetch after reset is at 0100h
// - only 03eh and 03fh configure the device
// - erased ffh options give low voltage reset on, internal rc clock
// - register file reached over separate eight-bit bus
// - top 64 bytes hold working, system and peripheral registers
// - 00h to bfh are general purpose registers
// - 245 bytes: 208 general purpose plus 37 control
// - one register page only, no page select
// - serial data driven by device on reads, tool on writes
// - programming voltage level selects write or read mode
module amso_core (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic cpu_fetch,
	input wire logic [11:0] cpu_pc_next,
	output logic [11:0] prog_addr,
	input wire logic [7:0] prog_rdata,
	output logic [7:0] fetch_data,
	output logic fetch_valid,
	output logic cpu_start,
	output logic [7:0] cpu_reset_pc_lo,
	output logic low_voltage_reset,
	output logic internal_rc,
	output logic opt_cell_hit,
	output logic vector_hit,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_ctrl_sel,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic vpp_high,
	input wire logic prog_mode,
	input wire logic prog_bit,
	output logic prog_sda_bit,
	output logic flash_write_mode
);
	amso_pkg::amso_state_t state;
	amso_pkg::amso_state_t next_state;
	amso_pkg::amso_cfg_t cfg;
	amso_pkg::amso_sda_t sda_q;
	logic [11:0] pc;
	logic [11:0] next_pc;
	logic [7:0] rf_rdata;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] vpp_sync;
	logic [1:0] mode_sync;
	logic scl_prev;
	logic fetch_pend;
	logic opt_pend;
	logic vec_pend;

	// opt cell and vector region decoding is reused for fetch and flags
	function automatic logic in_span(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
		in_span = (a >= lo) && (a <= hi);
	endfunction

	wire running = (state == amso_pkg::AMSO_ST_RUN);
	wire [11:0] fetch_addr = cpu_pc_next & amso_pkg::PROG_TOP;
	wire fetch_opt = in_span(fetch_addr, amso_pkg::OPT_LO, amso_pkg::OPT_HI);
	wire fetch_vec = in_span(fetch_addr, 12'h000, amso_pkg::VEC_TOP) && !fetch_opt;
	wire ctrl_space = reg_addr > amso_pkg::WORK_HI;
	wire gp_space = reg_addr <= amso_pkg::GP_TOP;
	wire write_mode = vpp_sync[1] && mode_sync[1];
	wire read_mode = !vpp_sync[1] && mode_sync[1];
	wire scl_rise = scl_sync[1] && !scl_prev;
	wire take_fetch = running && cpu_fetch && !mode_sync[1];

	// start-up walk: read 03eh, then 03fh, then release the cpu at 0100h
	always_comb begin
		next_state = state;
		next_pc = pc;
		case (state)
			amso_pkg::AMSO_ST_OPT_A: begin
				next_state = amso_pkg::AMSO_ST_OPT_B;
				next_pc = amso_pkg::OPT_B;
			end
			amso_pkg::AMSO_ST_OPT_B: begin
				next_state = amso_pkg::AMSO_ST_RUN;
				next_pc = amso_pkg::RESET_PC;
			end
			amso_pkg::AMSO_ST_RUN: begin
				if (cpu_fetch && !mode_sync[1]) begin
					next_pc = fetch_addr;
				end
			end
			default: begin
				next_state = amso_pkg::AMSO_ST_OPT_A;
				next_pc = amso_pkg::OPT_A;
			end
		endcase
	end

	// address and state; address held to 12 bits so it wraps in 4 kbytes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= amso_pkg::AMSO_ST_OPT_A;
			pc <= amso_pkg::OPT_A;
		end else begin
			state <= next_state;
			pc <= next_pc;
		end
	end

	// options captured once: erased ffh leaves both enables set; 03ch/03dh never read
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= '{low_voltage_reset: 1'b1, internal_rc: 1'b1, opt_a: amso_pkg::ERASED, opt_b: amso_pkg::ERASED};
		end else if (state == amso_pkg::AMSO_ST_OPT_A) begin
			cfg.opt_a <= prog_rdata;
			cfg.low_voltage_reset <= prog_rdata[amso_pkg::LVR_BIT];
		end else if (state == amso_pkg::AMSO_ST_OPT_B) begin
			cfg.opt_b <= prog_rdata;
			cfg.internal_rc <= prog_rdata[amso_pkg::OSC_BIT];
		end
	end

	// fetch path; flags wait one cycle so they line up with the data of the new address
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fetch_data <= 8'h00;
			fetch_valid <= 1'b0;
			opt_cell_hit <= 1'b0;
			vector_hit <= 1'b0;
			fetch_pend <= 1'b0;
			opt_pend <= 1'b0;
			vec_pend <= 1'b0;
		end else begin
			fetch_data <= prog_rdata;
			fetch_pend <= take_fetch;
			opt_pend <= take_fetch && fetch_opt;
			vec_pend <= take_fetch && fetch_vec;
			fetch_valid <= fetch_pend;
			opt_cell_hit <= opt_pend;
			vector_hit <= vec_pend;
		end
	end

	// outputs that follow state, the captured options and the next program address
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cpu_start <= 1'b0;
			cpu_reset_pc_lo <= 8'h00;
			low_voltage_reset <= 1'b1;
			internal_rc <= 1'b1;
			prog_addr <= amso_pkg::OPT_A;
		end else begin
			cpu_start <= running;
			cpu_reset_pc_lo <= amso_pkg::RESET_PC[7:0];
			low_voltage_reset <= cfg.low_voltage_reset;
			internal_rc <= cfg.internal_rc;
			prog_addr <= next_pc;
		end
	end

	// single page gp store; control space answered by peripherals outside
	amso_regfile #(
		.DEPTH(amso_pkg::GP_BYTES)
	) u_regfile (
		.clock(clock),
		.arst_n(arst_n),
		.wr_en(reg_wr && !ctrl_space),
		.addr(reg_addr),
		.wdata(reg_wdata),
		.rdata(rf_rdata)
	);

	// register bus return; reg_ctrl_sel tells the cpu to take peripheral data instead
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
			reg_ctrl_sel <= 1'b0;
		end else begin
			reg_rdata <= rf_rdata;
			reg_ctrl_sel <= ctrl_space;
		end
	end

	// pins come from outside the clock domain; two flops before use
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			scl_sync <= 2'b00;
			sda_sync <= 2'b00;
			vpp_sync <= 2'b00;
			mode_sync <= 2'b00;
			scl_prev <= 1'b0;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			vpp_sync <= {vpp_sync[0], vpp_high};
			mode_sync <= {mode_sync[0], prog_mode};
			scl_prev <= scl_sync[1];
		end
	end

	// serial data: drive only when reading, release on writes; clock never driven
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sda_q <= '{sda_out: 1'b0, sda_oe: 1'b0};
			prog_sda_bit <= 1'b0;
			flash_write_mode <= 1'b0;
		end else begin
			sda_q.sda_oe <= read_mode;
			if (read_mode) begin
				sda_q.sda_out <= prog_bit;
			end
			if (write_mode && scl_rise) begin
				prog_sda_bit <= sda_sync[1];
			end
			flash_write_mode <= write_mode;
		end
	end
	assign sda_out = sda_q.sda_out;
	assign sda_oe = sda_q.sda_oe;
endmodule

// ### testbench/amso_core_assertions.sv
// Purpose: port checks for amso_core
// Assumes: prog_mode stays low while fetching
// Notes: hit flags are judged against the registered address
`timescale 1ns/1ps
module amso_core_chk (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic cpu_fetch,
	input wire logic [11:0] cpu_pc_next,
	input wire logic [11:0] prog_addr,
	input wire logic [7:0] prog_rdata,
	input wire logic [7:0] fetch_data,
	input wire logic fetch_valid,
	input wire logic cpu_start,
	input wire logic low_voltage_reset,
	input wire logic internal_rc,
	input wire logic opt_cell_hit,
	input wire logic vector_hit,
	input wire logic [7:0] reg_addr,
	input wire logic reg_ctrl_sel,
	input wire logic sda_oe,
	input wire logic vpp_high,
	input wire logic prog_mode,
	input wire logic flash_write_mode
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// a fetch counts only once the mode synchroniser has settled low
	wire take = cpu_start && cpu_fetch && !prog_mode;
	// option window in program space
	wire opt_win = prog_addr >= 12'h03c && prog_addr <= 12'h03f;

	chk_fetch_addr: assert property (take && $past(!prog_mode, 3) |=> prog_addr == $past(cpu_pc_next))
		else $error("fetch address not taken");
	chk_fetch_data: assert property (take && $past(!prog_mode, 3) ##1 1 |=> fetch_valid && fetch_data == $past(prog_rdata))
		else $error("fetch data wrong");
	chk_start_addr: assert property ($rose(cpu_start) |-> $past(prog_addr) == amso_pkg::RESET_PC)
		else $error("first fetch address wrong");
	chk_opt_cell: assert property (opt_cell_hit == (fetch_valid && $past(opt_win)))
		else $error("option cell flag wrong");
	chk_vector_hit: assert property (vector_hit == (fetch_valid && $past(prog_addr) <= 12'h0ff && !$past(opt_win)))
		else $error("vector flag wrong");
	chk_opts_held: assert property (cpu_start |=> $stable({low_voltage_reset, internal_rc}))
		else $error("options changed while running");
	chk_ctrl_sel: assert property (1 |=> reg_ctrl_sel == ($past(reg_addr) > 8'hcf))
		else $error("control space select wrong");
	chk_read_drive: assert property ((prog_mode && !vpp_high) [*6] |-> sda_oe && !flash_write_mode)
		else $error("read mode not driving data");
	chk_write_mode: assert property ((prog_mode && vpp_high) [*6] |-> !sda_oe && flash_write_mode)
		else $error("write mode drives data");
endmodule
bind amso_core amso_core_chk amso_core_chk_inst (.*);

// ### testbench/amso_flash_model.sv
// Purpose: flash array model behind amso_core
// Assumes: combinational read of the addressed byte
// Notes: option cells left erased; other bytes hold an address pattern
`timescale 1ns/1ps
module amso_flash_model (
	input wire logic [11:0] prog_addr,
	output logic [7:0] prog_rdata
);
	// unused option cells filled with ff, live ones erased
	assign prog_rdata = (prog_addr >= 12'h03c && prog_addr <= 12'h03f) ? 8'hff
		: prog_addr[7:0] ^ {prog_addr[11:8], 4'h5};
endmodule

// ### testbench/testbench.sv
// Purpose: directed bench for amso_core
// Assumes: flash model answers combinationally
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module testbench;
	logic clock = 1'h0, arst_n = 1'h0, cpu_fetch = 1'h0, reg_wr = 1'h0, scl_in = 1'h0, sda_in = 1'h0;
	logic vpp_high = 1'h0, prog_mode = 1'h0, prog_bit = 1'h0, fetch_valid, cpu_start, low_voltage_reset;
	logic internal_rc, opt_cell_hit, vector_hit, reg_ctrl_sel, sda_out, sda_oe, prog_sda_bit, flash_write_mode;
	logic [11:0] cpu_pc_next = 12'h000, prog_addr;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, prog_rdata, fetch_data, reg_rdata, cpu_reset_pc_lo;
	int num_errors = 0, checked = 0;

	amso_core amso_core_inst (
		.clock(clock),
		.arst_n(arst_n),
		.cpu_fetch(cpu_fetch),
		.cpu_pc_next(cpu_pc_next),
		.prog_addr(prog_addr),
		.prog_rdata(prog_rdata),
		.fetch_data(fetch_data),
		.fetch_valid(fetch_valid),
		.cpu_start(cpu_start),
		.cpu_reset_pc_lo(cpu_reset_pc_lo),
		.low_voltage_reset(low_voltage_reset),
		.internal_rc(internal_rc),
		.opt_cell_hit(opt_cell_hit),
		.vector_hit(vector_hit),
		.reg_wr(reg_wr),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_ctrl_sel(reg_ctrl_sel),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.vpp_high(vpp_high),
		.prog_mode(prog_mode),
		.prog_bit(prog_bit),
		.prog_sda_bit(prog_sda_bit),
		.flash_write_mode(flash_write_mode)
	);
	amso_flash_model amso_flash_model_inst (.prog_addr(prog_addr), .prog_rdata(prog_rdata));

	always #10 clock = ~clock;

	task ck(input string n, input logic [11:0] e, input logic [11:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task close_out;
		$display("mismatches %0d of %0d checks", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// one fetch, then judge data and region flags
	task fetch(input logic [11:0] a, input logic o, input logic v);
		cpu_fetch = 1'h1;
		cpu_pc_next = a;
		@(negedge clock);
		cpu_fetch = 1'h0;
		@(negedge clock);
		ck("fetch_valid", 1'h1, fetch_valid);
		ck("fetch_data", (a >= 12'h03c && a <= 12'h03f) ? 8'hff : a[7:0] ^ {a[11:8], 4'h5}, fetch_data);
		ck("opt_cell_hit", o, opt_cell_hit);
		ck("vector_hit", v, vector_hit);
	endtask

	// write if w, then read back after the two-stage read path
	task rw(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, input logic w);
		reg_wr = w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_wr = 1'h0;
		repeat (3) @(negedge clock);
		ck("reg_rdata", e, reg_rdata);
		ck("reg_ctrl_sel", a > 8'hcf, reg_ctrl_sel);
	endtask

	task t_reset;
		repeat (12) @(negedge clock);
		ck("lvr_in_reset", 1'h1, low_voltage_reset);
		ck("pc_lo", 8'h00, cpu_reset_pc_lo);
		arst_n = 1'h1;
		for (int i = 0; i < 10 && cpu_start !== 1'h1; i++) @(negedge clock);
		ck("cpu_start", 1'h1, cpu_start);
		ck("prog_addr", amso_pkg::RESET_PC, prog_addr);
		ck("low_voltage_reset", 1'h1, low_voltage_reset);
		ck("internal_rc", 1'h1, internal_rc);
		$display("reset test done");
	endtask

	task t_fetch;
		fetch(12'h03e, 1'h1, 1'h0);
		fetch(12'h03c, 1'h1, 1'h0);
		fetch(12'h0f6, 1'h0, 1'h1);
		fetch(12'h040, 1'h0, 1'h1);
		fetch(12'h100, 1'h0, 1'h0);
		fetch(12'hfff, 1'h0, 1'h0);
		$display("fetch test done");
	endtask

	task t_regs;
		rw(8'h00, 8'ha5, 8'ha5, 1'h1);
		rw(8'hbf, 8'h5a, 8'h5a, 1'h1);
		rw(8'hc0, 8'h3c, 8'h3c, 1'h1);
		rw(8'hcf, 8'hc3, 8'hc3, 1'h1);
		rw(8'hd0, 8'h77, 8'h00, 1'h1);
		rw(8'hff, 8'h11, 8'h00, 1'h1);
		rw(8'h00, 8'h00, 8'ha5, 1'h0);
		$display("register test done");
	endtask

	task t_prog;
		prog_mode = 1'h1;
		prog_bit = 1'h1;
		repeat (6) @(negedge clock);
		ck("sda_oe_read", 1'h1, sda_oe);
		ck("sda_out_read", 1'h1, sda_out);
		ck("write_mode_read", 1'h0, flash_write_mode);
		vpp_high = 1'h1;
		sda_in = 1'h1;
		repeat (6) @(negedge clock);
		ck("sda_oe_write", 1'h0, sda_oe);
		ck("write_mode", 1'h1, flash_write_mode);
		scl_in = 1'h1;
		repeat (6) @(negedge clock);
		ck("prog_sda_bit", 1'h1, prog_sda_bit);
		scl_in = 1'h0;
		sda_in = 1'h0;
		repeat (6) @(negedge clock);
		scl_in = 1'h1;
		repeat (6) @(negedge clock);
		ck("prog_sda_bit", 1'h0, prog_sda_bit);
		scl_in = 1'h0;
		prog_mode = 1'h0;
		vpp_high = 1'h0;
		$display("programming test done");
	endtask

	initial begin
		t_reset;
		t_fetch;
		t_regs;
		t_prog;
		close_out;
	end

	// tests need well under 500 cycles; ten times that is a hang
	initial begin
		#100us;
		num_errors++;
		close_out;
	end
endmodule
